// *** rtl/upg_consts.svh ***
// constants of the upper port group and direction bank
`ifndef UPG_CONSTS_SVH
`define UPG_CONSTS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define UPG_IDX_DIR0     16'hFF20
`define UPG_IDX_DIR1     16'hFF21
`define UPG_IDX_DIR2     16'hFF22
`define UPG_IDX_DIR3     16'hFF23
`define UPG_IDX_DIR4     16'hFF24
`define UPG_IDX_DIR5     16'hFF25
`define UPG_IDX_DIR6     16'hFF26
`define UPG_IDX_DIR7     16'hFF27
`define UPG_IDX_DIR12    16'hFF2C
`define UPG_IDX_DIR14    16'hFF2E
`define UPG_IDX_DATA7    16'hFF07
`define UPG_IDX_DATA12   16'hFF0C
`define UPG_IDX_DATA13   16'hFF0D
`define UPG_IDX_DATA14   16'hFF0E
`define UPG_IDX_PU7      16'hFF37
`define UPG_IDX_PORT12_PULLUP_SELECT     16'hFF3C
`define UPG_IDX_PORT14_PULLUP_SELECT     16'hFF3E
`define UPG_IDX_OSC      16'hFF9F

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define UPG_DIR_RESET    8'hFF
`define UPG_LATCH_RESET  8'h00
`define UPG_PU_RESET     8'h00
`define UPG_OSC_RESET    8'h00
`define UPG_FIX_NONE     8'h00
`define UPG_FIX_P0       8'h80
`define UPG_FIX_P3TO6    8'hF0
`define UPG_FIX_P12      8'hE0
`define UPG_FIX_P14      8'hFC
`define UPG_MASK_P12     8'h1F
`define UPG_MASK_P13     8'h01
`define UPG_MASK_P14     8'h03
`define UPG_MASK_PORT12_PULLUP_SELECT    8'h01
`define UPG_MASK_OSC     8'h0F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UPG_OSC_MAIN_LSB 0
`define UPG_OSC_SUB_LSB  2
`define UPG_MAIN_PINS    8'h06
`define UPG_SUB_PINS     8'h18
`define UPG_MAIN_CLK_BIT 1
`define UPG_SUB_CLK_BIT  3

`endif

// *** rtl/upg_pkg.sv ***
// types of the upper port group and direction bank
package upg_pkg;

   // clock pin mode, two bits per oscillator
   typedef enum logic [1:0] {
      upg_clk_port      = 2'b00,
      upg_clk_resonator = 2'b01,
      upg_clk_reserved  = 2'b10,
      upg_clk_external  = 2'b11
   } upg_clk_mode_t;

   // one port's pin drive, unused bits stay zero / released
   typedef struct packed {
      logic [7:0] dout;
      logic [7:0] oe_n;
      logic [7:0] pullup_en;
   } upg_pins_t;

   // direction registers for ports outside this block
   typedef struct packed {
      logic [7:0] port0_direction;
      logic [7:0] port1_direction;
      logic [7:0] port2_direction;
      logic [7:0] port3_direction;
      logic [7:0] port4_direction;
      logic [7:0] port5_direction;
      logic [7:0] port6_direction;
   } upg_dir_bank_t;

endpackage

// *** rtl/upg_port_group.sv ***
// upper port group: ports 7, 12, 13, 14 and direction register bank
`include "upg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module upg_port_group (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // port 7
   input  wire logic [7:0]            port7_pin_in,
   output var  upg_pkg::upg_pins_t    port7_pins,
   // port 12 and clock pins
   input  wire logic [4:0]            port12_pin_in,
   output var  upg_pkg::upg_pins_t    port12_pins,
   output logic                       main_osc_select,
   output logic                       sub_osc_select,
   output logic                       main_ext_clock_in,
   output logic                       sub_ext_clock_in,
   // port 13
   output logic                       port13_output_bit,
   // port 14 and its alternate outputs
   input  wire logic [1:0]            port14_pin_in,
   input  wire logic [1:0]            port14_alt_drive,
   input  wire logic [1:0]            port14_alt_data,
   output var  upg_pkg::upg_pins_t    port14_pins,
   // direction registers of ports 0 to 6
   output var  upg_pkg::upg_dir_bank_t dir_bank
);

   // ----------------------------------------------------------------
   // direction bank layout
   // ----------------------------------------------------------------
   localparam int NDIR = 10;
   localparam int K7   = 7;
   localparam int K12  = 8;
   localparam int K14  = 9;
   localparam logic [15:0] DIR_IDX [NDIR] = '{
      `UPG_IDX_DIR0, `UPG_IDX_DIR1, `UPG_IDX_DIR2, `UPG_IDX_DIR3,
      `UPG_IDX_DIR4, `UPG_IDX_DIR5, `UPG_IDX_DIR6, `UPG_IDX_DIR7,
      `UPG_IDX_DIR12, `UPG_IDX_DIR14};
   localparam logic [7:0] DIR_FIX [NDIR] = '{
      `UPG_FIX_P0, `UPG_FIX_NONE, `UPG_FIX_NONE, `UPG_FIX_P3TO6,
      `UPG_FIX_P3TO6, `UPG_FIX_P3TO6, `UPG_FIX_P3TO6, `UPG_FIX_NONE,
      `UPG_FIX_P12, `UPG_FIX_P14};

   logic [7:0] dir_q [NDIR];
   logic [7:0] lat7;
   logic [4:0] lat12;
   logic       lat13;
   logic [1:0] lat14;
   logic [7:0] pu7;
   logic       port12_pullup_select;
   logic [1:0] port14_pullup_select;
   logic [7:0] osc_q;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire [15:0] reg_idx  = paddr[17:2];
   wire        high_ok  = (paddr[31:18] == 14'h0000);
   wire        hit_d7   = high_ok && (reg_idx == `UPG_IDX_DATA7);
   wire        hit_d12  = high_ok && (reg_idx == `UPG_IDX_DATA12);
   wire        hit_d13  = high_ok && (reg_idx == `UPG_IDX_DATA13);
   wire        hit_d14  = high_ok && (reg_idx == `UPG_IDX_DATA14);
   wire        hit_pu7  = high_ok && (reg_idx == `UPG_IDX_PU7);
   wire        hit_port12_pullup_select = high_ok && (reg_idx == `UPG_IDX_PORT12_PULLUP_SELECT);
   wire        hit_port14_pullup_select = high_ok && (reg_idx == `UPG_IDX_PORT14_PULLUP_SELECT);
   wire        hit_osc  = high_ok && (reg_idx == `UPG_IDX_OSC);
   wire [NDIR-1:0] dir_hit;
   wire [7:0]  dir_or [NDIR+1];

   assign dir_or[0] = 8'h00;
   genvar k;
   generate
      for (k = 0; k < NDIR; k++) begin : g_dir
         assign dir_hit[k]  = high_ok && (reg_idx == DIR_IDX[k]);
         assign dir_or[k+1] = dir_or[k] | (dir_hit[k] ? dir_q[k] : 8'h00);
      end
   endgenerate

   wire addr_ok = (|dir_hit) | hit_d7 | hit_d12 | hit_d13 | hit_d14 |
                  hit_pu7 | hit_port12_pullup_select | hit_port14_pullup_select | hit_osc;
   wire setup   = psel & ~penable;
   wire wr_en   = psel & penable & pwrite & addr_ok;

   // ----------------------------------------------------------------
   // clock pin ownership
   // ----------------------------------------------------------------
   wire upg_pkg::upg_clk_mode_t main_mode =
      upg_pkg::upg_clk_mode_t'(osc_q[`UPG_OSC_MAIN_LSB +: 2]);
   wire upg_pkg::upg_clk_mode_t sub_mode =
      upg_pkg::upg_clk_mode_t'(osc_q[`UPG_OSC_SUB_LSB +: 2]);
   // the reserved code leaves the pins to the port, the safer default
   wire main_take = (main_mode == upg_pkg::upg_clk_resonator) ||
                    (main_mode == upg_pkg::upg_clk_external);
   wire sub_take  = (sub_mode == upg_pkg::upg_clk_resonator) ||
                    (sub_mode == upg_pkg::upg_clk_external);
   wire main_ext  = (main_mode == upg_pkg::upg_clk_external);
   wire sub_ext   = (sub_mode == upg_pkg::upg_clk_external);
   wire [7:0] take_mask = (main_take ? `UPG_MAIN_PINS : 8'h00) |
                          (sub_take ? `UPG_SUB_PINS : 8'h00);
   wire [7:0] ext_mask  = (main_ext ? `UPG_MAIN_PINS : 8'h00) |
                          (sub_ext ? `UPG_SUB_PINS : 8'h00);

   assign main_osc_select   = main_take;
   assign sub_osc_select    = sub_take;
   assign main_ext_clock_in = main_ext & port12_pin_in[`UPG_MAIN_CLK_BIT];
   assign sub_ext_clock_in  = sub_ext & port12_pin_in[`UPG_SUB_CLK_BIT];

   // ----------------------------------------------------------------
   // read selection
   // ----------------------------------------------------------------
   wire [7:0] dir12   = dir_q[K12];
   wire [7:0] pin12   = {3'b000, port12_pin_in};
   wire [7:0] latch12 = {3'b000, lat12};
   wire [7:0] dir14   = dir_q[K14];
   wire [7:0] pin14   = {6'h00, port14_pin_in};
   wire [7:0] latch14 = {6'h00, lat14};
   wire [7:0] rd7  = (dir_q[K7] & port7_pin_in) | (~dir_q[K7] & lat7);
   wire [7:0] rd12 = ((dir12 & pin12) | (~dir12 & latch12)) &
                     ~ext_mask & `UPG_MASK_P12;
   wire [7:0] rd14 = ((dir14 & pin14) | (~dir14 & latch14)) &
                     `UPG_MASK_P14;
   wire [7:0] rd_mux = dir_or[NDIR] |
                       (hit_d7   ? rd7                  : 8'h00) |
                       (hit_d12  ? rd12                 : 8'h00) |
                       (hit_d13  ? {7'h00, lat13}       : 8'h00) |
                       (hit_d14  ? rd14                 : 8'h00) |
                       (hit_pu7  ? pu7                  : 8'h00) |
                       (hit_port12_pullup_select ? {7'h00, port12_pullup_select}        : 8'h00) |
                       (hit_port14_pullup_select ? {6'h00, port14_pullup_select}        : 8'h00) |
                       (hit_osc  ? osc_q                : 8'h00);

   // zero wait states: read data is caught in the setup cycle
   assign pready = 1'b1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
         pslverr <= ~addr_ok;
      end
   end

   // ----------------------------------------------------------------
   // direction registers
   // ----------------------------------------------------------------
   // byte writes only; a single-bit change is a software read-modify-
   // write, which is safe because every bit reads back as stored
   generate
      for (k = 0; k < NDIR; k++) begin : g_dir_reg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn)
               dir_q[k] <= `UPG_DIR_RESET;
            else if (wr_en && dir_hit[k])
               dir_q[k] <= pwdata[7:0] | DIR_FIX[k];
         end
      end
   endgenerate

   assign dir_bank.port0_direction = dir_q[0];
   assign dir_bank.port1_direction = dir_q[1];
   assign dir_bank.port2_direction = dir_q[2];
   assign dir_bank.port3_direction = dir_q[3];
   assign dir_bank.port4_direction = dir_q[4];
   assign dir_bank.port5_direction = dir_q[5];
   assign dir_bank.port6_direction = dir_q[6];

   // ----------------------------------------------------------------
   // latches, pull-up selects, oscillator mode
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lat7  <= `UPG_LATCH_RESET;
         lat12 <= 5'h00;
         lat13 <= 1'b0;
         lat14 <= 2'h0;
      end else if (wr_en) begin
         if (hit_d7)
            lat7 <= pwdata[7:0];
         if (hit_d12)
            lat12 <= pwdata[4:0];
         if (hit_d13)
            lat13 <= pwdata[0];
         if (hit_d14)
            lat14 <= pwdata[1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pu7   <= `UPG_PU_RESET;
         port12_pullup_select  <= 1'b0;
         port14_pullup_select  <= 2'h0;
         osc_q <= `UPG_OSC_RESET;
      end else if (wr_en) begin
         if (hit_pu7)
            pu7 <= pwdata[7:0];
         if (hit_port12_pullup_select)
            port12_pullup_select <= pwdata[0];
         if (hit_port14_pullup_select)
            port14_pullup_select <= pwdata[1:0];
         if (hit_osc)
            osc_q <= pwdata[7:0] & `UPG_MASK_OSC;
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   assign port7_pins.dout      = lat7;
   assign port7_pins.oe_n      = dir_q[K7];
   assign port7_pins.pullup_en = pu7 & dir_q[K7];

   // clock-owned pins are released whatever direction and latch say
   assign port12_pins.dout      = latch12 & ~take_mask;
   assign port12_pins.oe_n      = dir12 | take_mask | ~`UPG_MASK_P12;
   assign port12_pins.pullup_en = {7'h00, port12_pullup_select & dir12[0]};

   assign port13_output_bit = lat13;

   assign port14_pins.dout      = {6'h00, (port14_alt_drive & port14_alt_data)
                                  | (~port14_alt_drive & lat14)};
   assign port14_pins.oe_n      = dir14 | ~`UPG_MASK_P14;
   assign port14_pins.pullup_en = {6'h00, port14_pullup_select & dir14[1:0] &
                                  ~port14_alt_drive};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_DIR7_WRITE: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_en && dir_hit[K7] |=> port7_pins.oe_n == $past(pwdata[7:0]))
      else $error("port 7 direction did not take the written byte");

   AST_UNIMPL_ONES: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_en && dir_hit[K14] |=> dir_q[K14][7:2] == 6'h3F &&
                                dir_q[K14][1:0] == $past(pwdata[1:0]))
      else $error("port 14 direction unimplemented bits not one");

   AST_AFTER_RESET: assert property (@(posedge pclk)
      disable iff (!presetn)
      $past(!presetn) |-> dir_q[0] == 8'hFF && lat7 == 8'h00 &&
                          port7_pins.oe_n == 8'hFF)
      else $error("state after reset release is wrong");

   AST_P7_PULLUP: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_en && hit_pu7
      |=> port7_pins.pullup_en == ($past(pwdata[7:0]) & dir_q[K7]))
      else $error("port 7 pull-up does not follow selection");

   AST_P12_PULLUP: assert property (@(posedge pclk)
      disable iff (!presetn)
      port12_pins.pullup_en[7:1] == 7'h00 &&
      (!port12_pins.pullup_en[0] || port12_pins.oe_n[0]))
      else $error("port 12 pull-up outside bit 0 or on driven pin");

   AST_OSC_TAKE: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_en && hit_osc && pwdata[1:0] == 2'b01
      |=> main_osc_select && port12_pins.oe_n[2:1] == 2'b11)
      else $error("main clock mode did not take its pins");

   AST_P13_RESET: assert property (@(posedge pclk)
      !presetn |-> !port13_output_bit)
      else $error("port 13 high during reset");

   AST_P13_WRITE: assert property (@(posedge pclk)
      disable iff (!presetn)
      wr_en && hit_d13 |=> port13_output_bit == $past(pwdata[0]))
      else $error("port 13 did not take written bit");

   AST_P7_READ: assert property (@(posedge pclk)
      disable iff (!presetn)
      setup && !pwrite && hit_d7 |=> prdata[7:0] ==
      (($past(dir_q[K7]) & $past(port7_pin_in)) | (~$past(dir_q[K7]) & lat7)))
      else $error("port 7 read mixes pin and latch wrongly");

   AST_EXT_ZERO: assert property (@(posedge pclk)
      disable iff (!presetn)
      setup && !pwrite && hit_d12 && main_ext |=> prdata[2:1] == 2'b00)
      else $error("clock pins not zero in external clock mode");

   AST_P14_ALT: assert property (@(posedge pclk)
      disable iff (!presetn)
      |port14_alt_drive |->
      (port14_pins.pullup_en[1:0] & port14_alt_drive) == 2'b00)
      else $error("port 14 pull-up on while alternate drives");

endmodule

`default_nettype wire

// *** test/test_upg_port_group.sv ***
// self-checking testbench of the upper port group and direction bank
`include "upg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module test_upg_port_group;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic                   pclk = 1'b0;
   logic                   presetn = 1'b1;
   logic                   psel = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite = 1'b0;
   logic [31:0]            paddr = 32'h00000000;
   logic [31:0]            pwdata = 32'h00000000;
   logic [31:0]            prdata;
   logic                   pready;
   logic                   pslverr;
   logic [7:0]             port7_pin_in = 8'h96;
   logic [4:0]             port12_pin_in = 5'h0B;
   logic [1:0]             port14_pin_in = 2'h0;
   logic [1:0]             port14_alt_drive = 2'h0;
   logic [1:0]             port14_alt_data = 2'h0;
   upg_pkg::upg_pins_t     port7_pins;
   upg_pkg::upg_pins_t     port12_pins;
   upg_pkg::upg_pins_t     port14_pins;
   upg_pkg::upg_dir_bank_t dir_bank;
   logic                   main_osc_select;
   logic                   sub_osc_select;
   logic                   main_ext_clock_in;
   logic                   sub_ext_clock_in;
   logic                   port13_output_bit;
   logic [7:0]             rd;
   logic                   er;
   int                     error_cnt = 0;
   int                     checked = 0;
   logic [15:0] dir_idx [10] = '{`UPG_IDX_DIR0, `UPG_IDX_DIR1,
      `UPG_IDX_DIR2, `UPG_IDX_DIR3, `UPG_IDX_DIR4, `UPG_IDX_DIR5,
      `UPG_IDX_DIR6, `UPG_IDX_DIR7, `UPG_IDX_DIR12, `UPG_IDX_DIR14};
   // bits that always read one in each direction register
   logic [7:0]  dir_fix [10] = '{8'h80, 8'h00, 8'h00, 8'hF0, 8'hF0,
      8'hF0, 8'hF0, 8'h00, 8'hE0, 8'hFC};

   always #5 pclk = ~pclk;

   upg_port_group dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .port7_pin_in, .port7_pins,
      .port12_pin_in, .port12_pins, .main_osc_select, .sub_osc_select,
      .main_ext_clock_in, .sub_ext_clock_in, .port13_output_bit,
      .port14_pin_in, .port14_alt_drive, .port14_alt_data,
      .port14_pins, .dir_bank
   );

   // ----------------------------------------------------------------
   // bus and check helpers
   // ----------------------------------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   // one transfer; leaves the caller 1 ns past the access edge
   task apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {14'h0000, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         $display("MISMATCH t=%0t apb transfer got no pready", $time);
      end
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask

   task wr(input logic [15:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask

   task rdc(input logic [15:0] idx, input logic [7:0] exp, input string s);
      apb(1'b0, idx, 8'h00);
      chk(rd, exp, s);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_reset;
      for (int i = 0; i < 10; i++) rdc(dir_idx[i], 8'hFF, "dir rst");
      chk({7'h0, dir_bank === {7{8'hFF}}}, 8'h01, "bank rst");
      chk(port7_pins.oe_n, 8'hFF, "p7 oe rst");
      chk(port12_pins.oe_n, 8'hFF, "p12 oe rst");
      chk(port14_pins.oe_n, 8'hFF, "p14 oe rst");
      chk(port7_pins.dout, 8'h00, "p7 latch rst");
      chk(port7_pins.pullup_en, 8'h00, "p7 pu rst");
      chk({7'h0, port13_output_bit}, 8'h00, "p13 rst");
      rdc(`UPG_IDX_DATA7, 8'h96, "p7 pin read");
      chk({7'h0, er}, 8'h00, "mapped no err");
      $display("test reset done");
   endtask

   task t_dir;
      for (int i = 0; i < 10; i++) begin
         wr(dir_idx[i], 8'h55 | dir_fix[i]);
         rdc(dir_idx[i], 8'h55 | dir_fix[i], "dir byte");
      end
      chk(dir_bank.port3_direction, 8'hF5, "bank p3");
      rdc(`UPG_IDX_DIR7, 8'h55, "dir7 rmw rd");
      wr(`UPG_IDX_DIR7, rd & 8'hFE);
      rdc(`UPG_IDX_DIR7, 8'h54, "dir7 bit");
      // deliberate zero write to the fixed bit
      wr(`UPG_IDX_DIR0, 8'h00);
      rdc(`UPG_IDX_DIR0, 8'h80, "dir0 fixed");
      chk(dir_bank.port0_direction, 8'h80, "bank p0");
      for (int i = 0; i < 10; i++) wr(dir_idx[i], 8'hFF);
      $display("test direction done");
   endtask

   task t_port7;
      wr(`UPG_IDX_DATA7, 8'hA5);
      wr(`UPG_IDX_DIR7, 8'h0F);
      chk(port7_pins.oe_n, 8'h0F, "p7 oe");
      chk(port7_pins.dout, 8'hA5, "p7 dout");
      @(posedge pclk);
      port7_pin_in <= 8'h3C;
      #1;
      rdc(`UPG_IDX_DATA7, 8'hAC, "p7 mixed read");
      wr(`UPG_IDX_PU7, 8'hFF);
      chk(port7_pins.pullup_en, 8'h0F, "p7 pu");
      $display("test port7 done");
   endtask

   task t_port12;
      wr(`UPG_IDX_PORT12_PULLUP_SELECT, 8'hFF);
      chk(port12_pins.pullup_en, 8'h01, "p12 pu");
      wr(`UPG_IDX_DATA12, 8'h1F);
      wr(`UPG_IDX_DIR12, 8'hE0);
      chk(port12_pins.oe_n, 8'hE0, "p12 oe");
      chk(port12_pins.dout, 8'h1F, "p12 dout");
      chk(port12_pins.pullup_en, 8'h00, "p12 pu out");
      wr(`UPG_IDX_OSC, 8'h05);
      chk(port12_pins.oe_n, 8'hFE, "p12 osc oe");
      chk(port12_pins.dout, 8'h01, "p12 osc dout");
      chk(8'({main_osc_select, sub_osc_select}), 8'h03, "osc sel");
      chk(8'({main_ext_clock_in, sub_ext_clock_in}), 8'h00, "no ext");
      rdc(`UPG_IDX_DATA12, 8'h1F, "p12 res read");
      wr(`UPG_IDX_OSC, 8'h0F);
      chk(8'({main_ext_clock_in, sub_ext_clock_in}), 8'h03, "ext");
      rdc(`UPG_IDX_DATA12, 8'h01, "p12 ext read");
      @(posedge pclk);
      port12_pin_in <= 5'h10;
      #1;
      chk(8'({main_ext_clock_in, sub_ext_clock_in}), 8'h00, "ext lo");
      // reserved code on both clocks leaves the pins to the port
      wr(`UPG_IDX_OSC, 8'h0A);
      chk(8'({main_osc_select, sub_osc_select}), 8'h00, "osc rsv");
      chk(port12_pins.oe_n, 8'hE0, "p12 rsv oe");
      wr(`UPG_IDX_OSC, 8'h00);
      chk(port12_pins.oe_n, 8'hE0, "p12 back");
      $display("test port12 done");
   endtask

   task t_port13;
      wr(`UPG_IDX_DATA13, 8'h01);
      chk({7'h0, port13_output_bit}, 8'h01, "p13 high");
      rdc(`UPG_IDX_DATA13, 8'h01, "p13 read");
      @(posedge pclk);
      presetn <= 1'b0;
      #1;
      chk({7'h0, port13_output_bit}, 8'h00, "p13 in rst");
      chk(port7_pins.dout, 8'h00, "p7 latch clr");
      chk(port12_pins.oe_n, 8'hFF, "p12 oe clr");
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      rdc(`UPG_IDX_DIR7, 8'hFF, "dir7 rst2");
      $display("test port13 done");
   endtask

   task t_port14;
      wr(`UPG_IDX_DATA14, 8'h03);
      wr(`UPG_IDX_DIR14, 8'hFC);
      chk(port14_pins.oe_n, 8'hFC, "p14 oe");
      chk(port14_pins.dout, 8'h03, "p14 dout");
      @(posedge pclk);
      port14_alt_drive <= 2'b01;
      port14_alt_data <= 2'b00;
      port14_pin_in <= 2'b01;
      #1;
      chk(port14_pins.dout, 8'h02, "p14 alt");
      rdc(`UPG_IDX_DATA14, 8'h03, "p14 latch rd");
      wr(`UPG_IDX_DIR14, 8'hFF);
      wr(`UPG_IDX_PORT14_PULLUP_SELECT, 8'h03);
      chk(port14_pins.pullup_en, 8'h02, "p14 pu");
      rdc(`UPG_IDX_DATA14, 8'h01, "p14 pin rd");
      $display("test port14 done");
   endtask

   task t_unmapped;
      wr(16'hFF28, 8'h00);
      chk({7'h0, er}, 8'h01, "unmapped wr err");
      apb(1'b0, 16'hFF28, 8'h00);
      chk({7'h0, er}, 8'h01, "unmapped rd err");
      chk(rd, 8'h00, "unmapped rd data");
      $display("test unmapped done");
   endtask

   task complete_run;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // the whole run needs a few microseconds; this is a hang guard
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end

   initial begin
      // a falling edge at time zero so the asynchronous reset fires at once
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      #1;
      t_reset();
      t_dir();
      t_port7();
      t_port12();
      t_port13();
      t_port14();
      t_unmapped();
      complete_run();
   end
endmodule

`default_nettype wire
